// file: verilog/pmcm_regs.vh
`ifndef PMCM_REGS_VH
`define PMCM_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMCM_OSC_OFS   8'h00
`define PMCM_TMR_OFS   8'h04
`define PMCM_CFG_OFS   8'h08
`define PMCM_INTC_OFS  8'h0c
`define PMCM_PIE_OFS   8'h10
`define PMCM_STAT_OFS  8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMCM_IDLE_BIT  7
`define PMCM_PFLAG_BIT 3
`define PMCM_TFLAG_BIT 6
`define PMCM_TEN_BIT   0
`define PMCM_WDT_BIT   0
`define PMCM_FSCM_BIT  1
`define PMCM_TWO_BIT   2
`define PMCM_EXT_BIT   3
`define PMCM_GIE_BIT   7
// ----------------------------------------
// Encodings, reset values and counts
// ----------------------------------------
`define PMCM_SRC_NONE  2'b00
`define PMCM_SRC_TMR   2'b01
`define PMCM_SRC_PRI   2'b10
`define PMCM_SRC_RC    2'b11
`define PMCM_SCS_RST   2'b11
`define PMCM_SW_OLD    8'h02
`define PMCM_SW_NEW    8'h03
`define PMCM_CSD_DEF   8
`endif

// file: verilog/pmcm_top.v
// Implementation choices: the APB interface to the registers and the register offsets.
`include "pmcm_regs.vh"

module pmcm_top #(
  parameter [7:0] CSD_CYC = `PMCM_CSD_DEF
) (
  input  wire        sys_clk,         // System clock
  input  wire        rst_n,           // Sync reset, active low
  input  wire        psel,            // APB select
  input  wire        penable,         // APB enable
  input  wire        pwrite,          // APB direction
  input  wire [7:0]  paddr,           // APB byte address
  input  wire [31:0] pwdata,          // APB write data
  output reg  [31:0] prdata,          // APB read data
  output reg         pready,          // APB ready
  output reg         pslverr,         // APB error, unmapped
  input  wire        sleep_instr,     // Sleep instruction pulse
  input  wire        wdt_clr_instr,   // Watchdog clear pulse
  input  wire        wdt_timeout,     // Watchdog time-out pulse
  input  wire        clock_lost,      // Monitor saw clock loss
  input  wire [7:0]  irq_flags,       // Interrupt flag levels
  input  wire        pri_tick,        // Primary cycle enable
  input  wire        tmr_tick,        // Timer osc cycle enable
  input  wire        rc_tick,         // Internal RC cycle enable
  input  wire        pri_ready,       // Primary osc stable
  input  wire        tmr_running,     // Timer osc oscillating
  output reg         cpu_clk_en,      // CPU clock gate
  output reg         periph_clk_en,   // Peripheral clock gate
  output reg  [1:0]  clk_src,         // Source driving device
  output reg         pri_osc_en,      // Primary osc enable
  output reg         tmr_osc_en,      // Timer osc enable
  output reg         rc_osc_en,       // Internal RC enable
  output reg         cpu_resume,      // Execution resumes pulse
  output reg         int_vector,      // Branch to vector pulse
  output reg         wdt_reset,       // Watchdog reset pulse
  output reg         wdt_clear        // Watchdog clear pulse
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_RUN = 3'd0;
  localparam [2:0] ST_RDY = 3'd1;
  localparam [2:0] ST_SWO = 3'd2;
  localparam [2:0] ST_SWN = 3'd3;
  localparam [2:0] ST_SLP = 3'd4;
  localparam [2:0] ST_IDL = 3'd5;
  localparam [2:0] ST_WWT = 3'd6;
  localparam [2:0] ST_CSD = 3'd7;

  // Pick the bit of a source-indexed vector
  function sel_src;
    input [3:0] v;
    input [1:0] s;
    begin
      sel_src = v[s];
    end
  endfunction

  // ----------------------------------------
  // Software state and interrupt edge history
  // ----------------------------------------
  reg        idle_q;
  reg [1:0]  scs_q;
  reg        ten_q;
  reg        wdt_en_q;
  reg        fscm_q;
  reg        two_q;
  reg        ext_q;
  reg        gie_q;
  reg [7:0]  pie_q;
  reg [7:0]  irq_prev_q;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  reg [2:0]  st_q;
  reg [2:0]  st_d;
  reg [1:0]  cur_d;
  reg [1:0]  tgt_q;
  reg [1:0]  tgt_d;
  reg [7:0]  cnt_q;
  reg [7:0]  cnt_d;
  reg        ipend_q;
  reg        ipend_d;
  reg        wirq_q;
  reg        wirq_d;
  reg        cpu_d;
  reg        per_d;
  reg        res_d;
  reg        vec_d;
  reg        wrst_d;
  reg        sw_d;

  wire [3:0] tick_v = {rc_tick, pri_tick, tmr_tick, 1'b0};
  // External clock mode needs no startup timer wait
  wire [3:0] rdy_v  = {1'b1, pri_ready | ext_q, tmr_running, 1'b0};
  // A cleared field also names the internal oscillator
  wire [1:0] src    = (scs_q == `PMCM_SRC_NONE) ? `PMCM_SRC_RC : scs_q;
  wire       tmr_bad = (src == `PMCM_SRC_TMR) && !ten_q;
  wire       irq_rise = |(irq_flags & ~irq_prev_q & pie_q);
  wire       wake   = irq_rise | wdt_timeout;
  wire       slp_ok = sleep_instr && (st_q == ST_RUN) && !(idle_q && tmr_bad);
  wire       cur_tick = sel_src(tick_v, clk_src);
  wire       tgt_tick = sel_src(tick_v, tgt_q);

  // ----------------------------------------
  // Mode sequencer, next state
  // ----------------------------------------
  always @*
  begin
    st_d    = st_q;
    cur_d   = clk_src;
    tgt_d   = tgt_q;
    cnt_d   = cnt_q;
    ipend_d = ipend_q;
    wirq_d  = wirq_q;
    cpu_d   = cpu_clk_en;
    per_d   = periph_clk_en;
    res_d   = 1'b0;
    vec_d   = 1'b0;
    wrst_d  = 1'b0;
    case (st_q)
      ST_RUN:
      begin
        cpu_d = 1'b1;
        per_d = 1'b1;
        if (wdt_timeout)
          wrst_d = 1'b1;
        else if (slp_ok && !idle_q)
        begin
          // Sleep needs no switch: CPU and peripheral clocks just stop
          st_d  = ST_SLP;
          cur_d = `PMCM_SRC_NONE;
          cpu_d = 1'b0;
          per_d = 1'b0;
        end
        else if (slp_ok)
        begin
          ipend_d = 1'b1;
          cpu_d   = 1'b0;
          if (src == clk_src)
            st_d = ST_IDL;
          else
          begin
            tgt_d = src;
            st_d  = ST_RDY;
          end
        end
        else if ((src != clk_src) && !tmr_bad)
        begin
          tgt_d   = src;
          ipend_d = 1'b0;
          st_d    = ST_RDY;
        end
      end
      ST_RDY:
      begin
        // Keep running on the old source until the new one is up; idle entry toward the timer stops peripherals while waiting
        if (sel_src(rdy_v, tgt_q))
        begin
          st_d  = ST_SWO;
          cnt_d = 8'h00;
          cpu_d = 1'b0;
          per_d = 1'b0;
        end
        else if (ipend_q && (tgt_q == `PMCM_SRC_TMR))
          per_d = 1'b0;
      end
      ST_SWO:
      begin
        if (cur_tick)
        begin
          if (cnt_q == `PMCM_SW_OLD - 8'h01)
          begin
            st_d  = ST_SWN;
            cnt_d = 8'h00;
          end
          else
            cnt_d = cnt_q + 8'h01;
        end
      end
      ST_SWN:
      begin
        if (tgt_tick)
        begin
          if (cnt_q == `PMCM_SW_NEW - 8'h01)
          begin
            cur_d = tgt_q;
            per_d = 1'b1;
            cpu_d = !ipend_q;
            st_d  = ipend_q ? ST_IDL : ST_RUN;
          end
          else
            cnt_d = cnt_q + 8'h01;
        end
      end
      ST_IDL:
      begin
        if (wake)
        begin
          st_d   = ST_CSD;
          cnt_d  = 8'h00;
          wirq_d = irq_rise;
        end
      end
      ST_SLP:
      begin
        if (wake)
        begin
          wirq_d = irq_rise;
          cnt_d  = 8'h00;
          if (two_q || fscm_q)
          begin
            cur_d = `PMCM_SRC_RC;
            per_d = 1'b1;
            st_d  = ST_CSD;
          end
          else
            st_d = ST_WWT;
        end
      end
      ST_WWT:
      begin
        // Unclocked until the chosen source reports ready
        if (sel_src(rdy_v, src))
        begin
          cur_d = src;
          per_d = 1'b1;
          st_d  = ST_CSD;
        end
      end
      ST_CSD:
      begin
        if (cur_tick)
        begin
          if (cnt_q == CSD_CYC - 8'h01)
          begin
            st_d    = ST_RUN;
            cpu_d   = 1'b1;
            per_d   = 1'b1;
            res_d   = 1'b1;
            vec_d   = wirq_q & gie_q;
            ipend_d = 1'b0;
          end
          else
            cnt_d = cnt_q + 8'h01;
        end
      end
      default:
        st_d = ST_RUN;
    endcase
    sw_d = (st_d == ST_RDY) || (st_d == ST_SWO) || (st_d == ST_SWN);
  end

  // ----------------------------------------
  // Sequencer and clock gate flops
  // ----------------------------------------
  // Reset lands in internal run with the RC clock on
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q          <= ST_RUN;
      clk_src       <= `PMCM_SRC_RC;
      tgt_q         <= `PMCM_SRC_RC;
      cnt_q         <= 8'h00;
      ipend_q       <= 1'b0;
      wirq_q        <= 1'b0;
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      cpu_resume    <= 1'b0;
      int_vector    <= 1'b0;
      wdt_reset     <= 1'b0;
      wdt_clear     <= 1'b0;
      pri_osc_en    <= 1'b0;
      tmr_osc_en    <= 1'b0;
      rc_osc_en     <= 1'b1;
      irq_prev_q    <= 8'h00;
    end
    else
    begin
      st_q          <= st_d;
      clk_src       <= cur_d;
      tgt_q         <= tgt_d;
      cnt_q         <= cnt_d;
      ipend_q       <= ipend_d;
      wirq_q        <= wirq_d;
      cpu_clk_en    <= cpu_d;
      periph_clk_en <= per_d;
      cpu_resume    <= res_d;
      int_vector    <= vec_d;
      wdt_reset     <= wrst_d;
      wdt_clear     <= slp_ok | wdt_clr_instr | (clock_lost & fscm_q);
      // Primary runs only while in use, targeted or awaited
      pri_osc_en    <= (cur_d == `PMCM_SRC_PRI) ||
                       (sw_d && (tgt_d == `PMCM_SRC_PRI)) ||
                       ((st_d == ST_WWT) && (src == `PMCM_SRC_PRI));
      tmr_osc_en    <= ten_q;
      rc_osc_en     <= (cur_d == `PMCM_SRC_RC) || wdt_en_q || fscm_q ||
                       (sw_d && (tgt_d == `PMCM_SRC_RC));
      irq_prev_q    <= irq_flags;
    end
  end

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  wire       setup = psel && !penable;
  wire       wr_en = psel && penable && pready && pwrite;
  wire       hit   = (paddr == `PMCM_OSC_OFS) || (paddr == `PMCM_TMR_OFS) ||
                     (paddr == `PMCM_CFG_OFS) || (paddr == `PMCM_INTC_OFS) ||
                     (paddr == `PMCM_PIE_OFS) || (paddr == `PMCM_STAT_OFS);
  reg [31:0] rd_d;

  // Read mux; flags are derived from the live source
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `PMCM_OSC_OFS:
      begin
        rd_d[`PMCM_IDLE_BIT]  = idle_q;
        rd_d[`PMCM_PFLAG_BIT] = (clk_src == `PMCM_SRC_PRI);
        rd_d[1:0]             = scs_q;
      end
      `PMCM_TMR_OFS:
      begin
        rd_d[`PMCM_TFLAG_BIT] = (clk_src == `PMCM_SRC_TMR);
        rd_d[`PMCM_TEN_BIT]   = ten_q;
      end
      `PMCM_CFG_OFS:
      begin
        rd_d[`PMCM_WDT_BIT]  = wdt_en_q;
        rd_d[`PMCM_FSCM_BIT] = fscm_q;
        rd_d[`PMCM_TWO_BIT]  = two_q;
        rd_d[`PMCM_EXT_BIT]  = ext_q;
      end
      `PMCM_INTC_OFS:
        rd_d[`PMCM_GIE_BIT] = gie_q;
      `PMCM_PIE_OFS:
        rd_d[7:0] = pie_q;
      `PMCM_STAT_OFS:
        rd_d[2:0] = st_q;
      default:
        rd_d = 32'h0000_0000;
    endcase
  end

  // Bus handshake and register writes; only software touches these
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      idle_q   <= 1'b0;
      scs_q    <= `PMCM_SCS_RST;
      ten_q    <= 1'b0;
      wdt_en_q <= 1'b0;
      fscm_q   <= 1'b0;
      two_q    <= 1'b0;
      ext_q    <= 1'b0;
      gie_q    <= 1'b0;
      pie_q    <= 8'h00;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
      if (wr_en)
      begin
        case (paddr)
          `PMCM_OSC_OFS:
          begin
            idle_q <= pwdata[`PMCM_IDLE_BIT];
            scs_q  <= pwdata[1:0];
          end
          `PMCM_TMR_OFS:
            ten_q <= pwdata[`PMCM_TEN_BIT];
          `PMCM_CFG_OFS:
          begin
            wdt_en_q <= pwdata[`PMCM_WDT_BIT];
            fscm_q   <= pwdata[`PMCM_FSCM_BIT];
            two_q    <= pwdata[`PMCM_TWO_BIT];
            ext_q    <= pwdata[`PMCM_EXT_BIT];
          end
          `PMCM_INTC_OFS:
            gie_q <= pwdata[`PMCM_GIE_BIT];
          `PMCM_PIE_OFS:
            pie_q <= pwdata[7:0];
          default:
            gie_q <= gie_q;
        endcase
      end
    end
  end

endmodule

// file: sim/pmcm_monitor.sv
`include "pmcm_regs.vh"
module pmcm_monitor (
  input logic        sys_clk,       // Clock
  input logic        rst_n,         // Reset
  input logic        psel,          // Select
  input logic        penable,       // Enable
  input logic        pwrite,        // Direction
  input logic [7:0]  paddr,         // Address
  input logic [31:0] pwdata,        // Write data
  input logic        pready,        // Ready
  input logic        sleep_instr,   // Sleep
  input logic        wdt_clr_instr, // Clear instr
  input logic        wdt_timeout,   // Time-out
  input logic        cpu_clk_en,    // CPU gate
  input logic        periph_clk_en, // Periph gate
  input logic [1:0]  clk_src,       // Source
  input logic        pri_osc_en,    // Primary en
  input logic        cpu_resume,    // Resume
  input logic        int_vector,    // Vector
  input logic        wdt_reset,     // Wdt reset
  input logic        wdt_clear      // Wdt clear
);
  logic       idle_q;
  logic [1:0] scs_q;
  // ----
  // Shadow of idle bit and source field, so sleep outcomes can be judged
  // ----
  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      idle_q <= 1'b0;
      scs_q  <= 2'b11;
    end
    else if (psel && penable && pready && pwrite && paddr == `PMCM_OSC_OFS)
    begin
      idle_q <= pwdata[7];
      scs_q  <= pwdata[1:0];
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  sleep_stop_a: assert property (
    sleep_instr && cpu_clk_en && !idle_q && !wdt_timeout
    |=> !cpu_clk_en && !periph_clk_en && clk_src == 2'b00 && wdt_clear)
    else $error("sleep did not stop clocks");
  idle_keep_a: assert property (
    sleep_instr && cpu_clk_en && idle_q && scs_q != 2'b01 && !wdt_timeout
    |=> !cpu_clk_en && periph_clk_en && $stable(clk_src))
    else $error("idle entry wrong");
  wdt_run_a: assert property (wdt_timeout && cpu_clk_en |=> wdt_reset)
    else $error("no reset on run time-out");
  wdt_asleep_a: assert property (wdt_timeout && !cpu_clk_en |=> !wdt_reset)
    else $error("reset on time-out while halted");
  resume_rise_a: assert property (cpu_resume |-> cpu_clk_en && !$past(cpu_clk_en))
    else $error("resume without cpu clock start");
  vector_resume_a: assert property (int_vector |-> cpu_resume)
    else $error("vector without resume");
  pri_src_a: assert property (clk_src == 2'b10 |-> pri_osc_en)
    else $error("primary source but oscillator off");
  clr_instr_a: assert property (wdt_clr_instr ##1 1'b1 |-> wdt_clear)
    else $error("clear instruction ignored");
endmodule
bind pmcm_top pmcm_monitor u_mon (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .sleep_instr, .wdt_clr_instr, .wdt_timeout, .cpu_clk_en,
  .periph_clk_en, .clk_src, .pri_osc_en, .cpu_resume, .int_vector, .wdt_reset, .wdt_clear);

// file: sim/pmcm_osc_model.sv
module pmcm_osc_model (
  input  logic sys_clk,     // Clock
  input  logic slow,        // Long warm-up
  input  logic pri_osc_en,  // Primary en
  input  logic tmr_osc_en,  // Timer en
  input  logic rc_osc_en,   // RC en
  output logic pri_tick,    // Primary cycle
  output logic tmr_tick,    // Timer cycle
  output logic rc_tick,     // RC cycle
  output logic pri_ready,   // Primary stable
  output logic tmr_running  // Timer running
);
  logic [5:0] pw_q = 6'h00;
  logic [5:0] tw_q = 6'h00;
  logic [1:0] tc_q = 2'h0;
  logic       rd_q = 1'b0;
  // ----
  // Primary and timer oscillators warm up after enable; all stop dead when disabled
  // ----
  always_ff @(posedge sys_clk)
  begin
    tc_q        <= tc_q + 2'h1;
    rd_q        <= ~rd_q;
    pw_q        <= pri_osc_en ? pw_q + {5'h00, pw_q != 6'h3f} : 6'h00;
    tw_q        <= tmr_osc_en ? tw_q + {5'h00, tw_q != 6'h3f} : 6'h00;
    pri_ready   <= pri_osc_en && pw_q >= (slow ? 6'h28 : 6'h06);
    tmr_running <= tmr_osc_en && tw_q >= (slow ? 6'h28 : 6'h06);
    pri_tick    <= pri_ready && pri_osc_en;
    tmr_tick    <= tmr_running && tmr_osc_en && tc_q == 2'h0;
    rc_tick     <= rc_osc_en && rd_q;
  end
endmodule

// file: sim/tb_power_mode_clock_manager.sv
`include "pmcm_regs.vh"
module tb_power_mode_clock_manager;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CSD = 8'h03;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 1;
  logic        sleep_instr = 0, wdt_clr_instr = 0, wdt_timeout = 0, clock_lost = 0;
  logic [7:0]  paddr = 8'h00, irq_flags = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, cpu_clk_en, periph_clk_en, pri_osc_en, tmr_osc_en;
  logic        rc_osc_en, cpu_resume, int_vector, wdt_reset, wdt_clear, er;
  logic        pri_tick, tmr_tick, rc_tick, pri_ready, tmr_running;
  logic [1:0]  clk_src;
  int          fail_count = 0, comparisons = 0, t, n;
  pmcm_top #(.CSD_CYC(CSD)) DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_instr, .wdt_clr_instr, .wdt_timeout,
    .clock_lost, .irq_flags, .pri_tick, .tmr_tick, .rc_tick, .pri_ready, .tmr_running,
    .cpu_clk_en, .periph_clk_en, .clk_src, .pri_osc_en, .tmr_osc_en, .rc_osc_en,
    .cpu_resume, .int_vector, .wdt_reset, .wdt_clear);
  pmcm_osc_model u_osc (.sys_clk, .slow, .pri_osc_en, .tmr_osc_en, .rc_osc_en,
    .pri_tick, .tmr_tick, .rc_tick, .pri_ready, .tmr_running);
  // ----
  // Clock, watchdog and shared tasks
  // ----
  always #5 sys_clk = ~sys_clk;
  initial
  begin
    #300us;
    fail_count++;
    give_verdict;
  end
  task automatic give_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic pulse(input int s);
    @(posedge sys_clk);
    if (s == 0) sleep_instr <= 1;
    if (s == 1) wdt_timeout <= 1;
    if (s == 2) wdt_clr_instr <= 1;
    @(posedge sys_clk);
    sleep_instr <= 0;
    wdt_timeout <= 0;
    wdt_clr_instr <= 0;
    #1;
  endtask
  // Counts ticks of the active source until the CPU resumes
  task automatic wait_resume;
    t = 0;
    n = 0;
    while (cpu_resume !== 1'b1 && n < 500)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (clk_src == 2'b10 ? pri_tick : clk_src == 2'b01 ? tmr_tick : rc_tick) t++;
    end
    check("resume", cpu_resume, 1);
  endtask
  task automatic wait_src(input logic [1:0] s);
    n = 0;
    while (clk_src !== s && n < 500)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("src", clk_src, s);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    check("rst_src", clk_src, 2'b11);
    check("rst_rc", rc_osc_en, 1);
    rdchk("rst_osc", `PMCM_OSC_OFS, 32'h3);
    apb(0, 8'h18, 32'h0);
    check("unmapped_err", er, 1);
    check("unmapped_data", rd, 0);
  endtask
  task automatic t_primary;
    apb(1, `PMCM_OSC_OFS, 32'h2);
    repeat (10) @(posedge sys_clk);
    #1;
    check("hold_rc", clk_src, 2'b11);
    check("pri_start", pri_osc_en, 1);
    n = 0;
    while (pri_ready !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    wait_src(2'b10);
    check("switch_len", n >= 4 && n <= 10, 1);
    check("cpu_kept", cpu_clk_en, 1);
    rdchk("pri_osc", `PMCM_OSC_OFS, 32'ha);
    slow <= 0;
  endtask
  task automatic t_pidle;
    apb(1, `PMCM_PIE_OFS, 32'h1);
    apb(1, `PMCM_INTC_OFS, 32'h80);
    apb(1, `PMCM_OSC_OFS, 32'h82);
    pulse(0);
    check("pi_cpu", cpu_clk_en, 0);
    check("pi_per", periph_clk_en, 1);
    check("pi_src", clk_src, 2'b10);
    rdchk("pi_osc", `PMCM_OSC_OFS, 32'h8a);
    @(posedge sys_clk);
    irq_flags <= 8'h01;
    wait_resume;
    check("pi_csd", t >= CSD && t <= CSD + 2, 1);
    check("pi_vec", int_vector, 1);
    check("pi_wsrc", clk_src, 2'b10);
    irq_flags <= 8'h00;
  endtask
  task automatic t_sleep;
    apb(1, `PMCM_OSC_OFS, 32'h2);
    pulse(0);
    check("sl_cpu", cpu_clk_en, 0);
    check("sl_per", periph_clk_en, 0);
    check("sl_src", clk_src, 2'b00);
    check("sl_clr", wdt_clear, 1);
    check("sl_pri", pri_osc_en, 0);
    rdchk("sl_osc", `PMCM_OSC_OFS, 32'h2);
    pulse(1);
    check("sl_nrst", wdt_reset, 0);
    wait_resume;
    check("sl_wsrc", clk_src, 2'b10);
    check("sl_vec", int_vector, 0);
  endtask
  task automatic t_run_wdt;
    pulse(1);
    check("run_rst", wdt_reset, 1);
    pulse(2);
    check("run_clr", wdt_clear, 1);
  endtask
  task automatic t_timer;
    apb(1, `PMCM_INTC_OFS, 32'h0);
    apb(1, `PMCM_OSC_OFS, 32'h81);
    pulse(0);
    check("ti_ign", cpu_clk_en, 1);
    check("ti_nclr", wdt_clear, 0);
    slow <= 1;
    // Sleep must meet the enable write before the run-mode switch starts
    apb(1, `PMCM_TMR_OFS, 32'h1);
    sleep_instr <= 1;
    @(posedge sys_clk);
    sleep_instr <= 0;
    @(posedge sys_clk);
    #1;
    check("ti_hold", periph_clk_en, 0);
    wait_src(2'b01);
    check("ti_per", periph_clk_en, 1);
    check("ti_pri", pri_osc_en, 0);
    rdchk("ti_tmr", `PMCM_TMR_OFS, 32'h41);
    rdchk("ti_osc", `PMCM_OSC_OFS, 32'h81);
    @(posedge sys_clk);
    irq_flags <= 8'h01;
    wait_resume;
    check("ti_vec", int_vector, 0);
    check("ti_wsrc", clk_src, 2'b01);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    #1;
    t_reset;
    t_primary;
    t_pidle;
    t_sleep;
    t_run_wdt;
    t_timer;
    give_verdict;
  end
endmodule
